// ---- rtl/fsac_fault_capture.sv ----
/*
 * Fault status and fault address capture: sticky hard fault flags,
 * memory protection and bus fault address registers with valid flags,
 * and a plain register port for privileged software.
 * Assumes the core delivers one-cycle fault pulses synchronous to clock.
 */
//
// Functional notes
// - Hard fault flags are sticky and clear only by a written one or reset.
// - Bit 30 sets when a configurable-priority fault escalates to hard fault.
// - Bit 1 sets on a bus fault during a vector table read, always a hard fault.
// - With bit 1 set the stacked return address is the preempted instruction.
// - The memory fault address holds the faulting address while its valid is one; a word write to it still replaces the value and leaves valid set.
// - For unaligned faults the memory fault address is the real faulting piece.
// - The bus fault address holds the faulting address while its valid is one; a word write to it still replaces the value and leaves valid set.
// - For unaligned faults the bus fault address is the requested address.
// - Unaligned or non-word accesses are not supported; they are dropped and set the access error flag.
// - A later fault may overwrite a fault address register with a new address.
// - An imprecise bus error leaves the bus fault address unwritten.
`timescale 1ns/1ps
`include "fsac_defines.svh"

module fsac_fault_capture
    import fsac_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst_b,
    // Register port
    input  wire fsac_req_t   req,
    output logic [31:0]      rdata,
    // Fault reports from the core
    input  wire fsac_fault_t fault,
    input  wire logic        debug_event,
    // Status toward the exception logic
    output logic             vector_read_fault_flag,
    output logic             stack_preempted_pc,
    output logic             memory_protection_address_valid,
    output logic             bus_address_valid
);

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic rst_meta_q;
    logic rst_sync_b;

    // Two stages so deassertion is clean against clock
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_q <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_b <= rst_meta_q;
        end
    end

    // ------------------------------------------------------------------
    // Access decode
    // ------------------------------------------------------------------
    logic ok_access;
    logic wr_hfs;
    logic wr_mem;
    logic wr_bus;
    logic wr_val;
    logic bad_access;

    // reject non-word access
    // Only aligned word accesses act; anything else is flagged and dropped
    assign ok_access  = (req.size == `FSAC_SIZE_WORD) && (req.addr[1:0] == 2'b00);
    assign bad_access = (req.wr || req.rd) && !ok_access;
    assign wr_hfs = req.wr && ok_access && (req.addr == `FSAC_OFF_HARD_FAULT_STATUS);
    assign wr_mem = req.wr && ok_access && (req.addr == `FSAC_OFF_MEM_FAULT_ADDR);
    assign wr_bus = req.wr && ok_access && (req.addr == `FSAC_OFF_BUS_FAULT_ADDR);
    assign wr_val = req.wr && ok_access && (req.addr == `FSAC_OFF_ADDR_VALID);

    // ------------------------------------------------------------------
    // Hard fault status flags
    // ------------------------------------------------------------------
    logic forced_q;
    logic vector_q;
    logic debug_q;
    logic clr_forced;
    logic clr_vector;
    logic clr_debug;

    // A written one clears a flag; written zeros leave it alone
    assign clr_forced = wr_hfs && req.wdata[`FSAC_BIT_FORCED];
    assign clr_vector = wr_hfs && req.wdata[`FSAC_BIT_VECTOR_READ];
    assign clr_debug  = wr_hfs && req.wdata[`FSAC_BIT_DEBUG_EVENT];

    // sticky set wins
    // A fault in the same cycle as a clearing write keeps the flag set
    always_ff @(posedge clock or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            forced_q <= 1'b0;
            vector_q <= 1'b0;
            debug_q  <= 1'b0;
        end else begin
            if (fault.forced)
                forced_q <= 1'b1;
            else if (clr_forced)
                forced_q <= 1'b0;
            if (fault.vector_read)
                vector_q <= 1'b1;
            else if (clr_vector)
                vector_q <= 1'b0;
            // Debug bit only sets from the debug side; a written one clears it
            if (debug_event)
                debug_q <= 1'b1;
            else if (clr_debug)
                debug_q <= 1'b0;
        end
    end

    assign vector_read_fault_flag = vector_q;
    assign stack_preempted_pc     = vector_q;

    // ------------------------------------------------------------------
    // Fault address registers
    // ------------------------------------------------------------------
    logic [31:0] mem_addr_q;
    logic [31:0] bus_addr_q;
    logic        mem_valid_q;
    logic        bus_valid_q;
    logic        bus_capture;
    logic        clr_mem_valid;
    logic        clr_bus_valid;

    assign bus_capture = fault.bus_fault && !fault.imprecise;

    // Valid flags clear by a written one in the shared valid word
    assign clr_mem_valid = wr_val && req.wdata[`FSAC_BIT_MEM_VALID];
    assign clr_bus_valid = wr_val && req.wdata[`FSAC_BIT_BUS_VALID];

    // core supplies the split piece address
    always_ff @(posedge clock or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            mem_addr_q  <= `FSAC_RST_WORD;
            mem_valid_q <= 1'b0;
        end else if (fault.mem_fault) begin
            mem_addr_q  <= fault.mem_addr;
            mem_valid_q <= 1'b1;
        end else begin
            if (wr_mem)
                mem_addr_q <= req.wdata;
            if (clr_mem_valid)
                mem_valid_q <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            bus_addr_q  <= `FSAC_RST_WORD;
            bus_valid_q <= 1'b0;
        end else if (bus_capture) begin
            bus_addr_q  <= fault.bus_addr;
            bus_valid_q <= 1'b1;
        end else begin
            if (wr_bus)
                bus_addr_q <= req.wdata;
            if (clr_bus_valid)
                bus_valid_q <= 1'b0;
        end
    end

    assign memory_protection_address_valid = mem_valid_q;
    assign bus_address_valid               = bus_valid_q;

    // ------------------------------------------------------------------
    // Access error status
    // ------------------------------------------------------------------
    logic access_err_q;

    // Sticky record of rejected accesses; set wins over clear
    always_ff @(posedge clock or negedge rst_sync_b) begin
        if (!rst_sync_b)
            access_err_q <= 1'b0;
        else if (bad_access)
            access_err_q <= 1'b1;
        else if (req.wr && ok_access && (req.addr == `FSAC_OFF_ACCESS_ERROR)
                 && req.wdata[0])
            access_err_q <= 1'b0;
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    logic [31:0] rd_d;

    always_comb begin
        rd_d = `FSAC_RST_WORD;
        case (req.addr)
            `FSAC_OFF_HARD_FAULT_STATUS: begin
                rd_d[`FSAC_BIT_DEBUG_EVENT] = debug_q;
                rd_d[`FSAC_BIT_FORCED]      = forced_q;
                rd_d[`FSAC_BIT_VECTOR_READ] = vector_q;
            end
            `FSAC_OFF_MEM_FAULT_ADDR: rd_d = mem_addr_q;
            `FSAC_OFF_BUS_FAULT_ADDR: rd_d = bus_addr_q;
            `FSAC_OFF_ADDR_VALID: begin
                rd_d[`FSAC_BIT_MEM_VALID] = mem_valid_q;
                rd_d[`FSAC_BIT_BUS_VALID] = bus_valid_q;
            end
            `FSAC_OFF_ACCESS_ERROR: rd_d[0] = access_err_q;
            default: rd_d = `FSAC_RST_WORD;
        endcase
    end

    // Data stands only in the cycle after the read strobe
    always_ff @(posedge clock or negedge rst_sync_b) begin
        if (!rst_sync_b)
            rdata <= `FSAC_RST_WORD;
        else if (req.rd && ok_access)
            rdata <= rd_d;
        else
            rdata <= `FSAC_RST_WORD;
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    // A second memory fault while the first address is still valid
    sequence s_mem_refault;
        mem_valid_q ##1 fault.mem_fault;
    endsequence

    // A second precise bus fault while the first address is still valid
    sequence s_bus_refault;
        bus_valid_q ##1 bus_capture;
    endsequence

    // Vector fault and its clearing write land on the same edge
    sequence s_vector_race;
        fault.vector_read && clr_vector;
    endsequence

    // Good word read of the status register
    sequence s_status_read;
        req.rd && ok_access && (req.addr == `FSAC_OFF_HARD_FAULT_STATUS);
    endsequence

    chk_forced_sticky: assert property (@(posedge clock) disable iff (!rst_sync_b)
        forced_q && !clr_forced |=> forced_q)
        else $error("forced flag dropped without clear");

    chk_vector_sticky: assert property (@(posedge clock) disable iff (!rst_sync_b)
        vector_q && !clr_vector |=> vector_q)
        else $error("vector flag dropped without clear");

    chk_vec_hold: assert property (@(posedge clock) disable iff (!rst_sync_b)
        s_vector_race |=> vector_q)
        else $error("set lost against clear");

    chk_forced_set: assert property (@(posedge clock) disable iff (!rst_sync_b)
        fault.forced |=> forced_q)
        else $error("forced flag not set");

    chk_vector_set: assert property (@(posedge clock) disable iff (!rst_sync_b)
        fault.vector_read |=> vector_read_fault_flag && stack_preempted_pc)
        else $error("vector read flag not set");

    chk_mem_addr_pair: assert property (@(posedge clock) disable iff (!rst_sync_b)
        fault.mem_fault |=> mem_valid_q && mem_addr_q == $past(fault.mem_addr))
        else $error("memory address not captured with valid");

    chk_mem_overwrite: assert property (@(posedge clock) disable iff (!rst_sync_b)
        s_mem_refault |=> mem_addr_q == $past(fault.mem_addr))
        else $error("later fault did not overwrite address");

    chk_mem_valid_hold: assert property (@(posedge clock) disable iff (!rst_sync_b)
        mem_valid_q && !fault.mem_fault && !clr_mem_valid && !wr_mem
        |=> mem_valid_q && $stable(mem_addr_q))
        else $error("memory address moved while valid");

    chk_bus_addr_pair: assert property (@(posedge clock) disable iff (!rst_sync_b)
        bus_capture |=> bus_valid_q && bus_addr_q == $past(fault.bus_addr))
        else $error("bus address not captured with valid");

    chk_bus_overwrite: assert property (@(posedge clock) disable iff (!rst_sync_b)
        s_bus_refault |=> bus_addr_q == $past(fault.bus_addr))
        else $error("later bus fault did not overwrite address");

    chk_bus_valid_hold: assert property (@(posedge clock) disable iff (!rst_sync_b)
        bus_valid_q && !bus_capture && !clr_bus_valid && !wr_bus
        |=> bus_valid_q && $stable(bus_addr_q))
        else $error("bus address moved while valid");

    chk_imprecise_hold: assert property (@(posedge clock) disable iff (!rst_sync_b)
        fault.bus_fault && fault.imprecise && !wr_bus |=> $stable(bus_addr_q))
        else $error("imprecise error changed bus address");

    chk_imprecise_valid: assert property (@(posedge clock) disable iff (!rst_sync_b)
        fault.bus_fault && fault.imprecise && !clr_bus_valid
        |=> bus_valid_q == $past(bus_valid_q))
        else $error("imprecise error changed bus valid");

    chk_bad_ignored: assert property (@(posedge clock) disable iff (!rst_sync_b)
        req.wr && !ok_access && !fault.mem_fault |=> $stable(mem_addr_q))
        else $error("unaligned write took effect");

    chk_bad_bus_ignored: assert property (@(posedge clock) disable iff (!rst_sync_b)
        req.wr && !ok_access && !bus_capture |=> $stable(bus_addr_q))
        else $error("unaligned write changed bus address");

    chk_access_err_set: assert property (@(posedge clock) disable iff (!rst_sync_b)
        bad_access |=> access_err_q)
        else $error("rejected access not recorded");

    chk_rdata_idle: assert property (@(posedge clock) disable iff (!rst_sync_b)
        !(req.rd && ok_access) |=> rdata == `FSAC_RST_WORD)
        else $error("read data without a good read");

    chk_reserved_zero: assert property (@(posedge clock) disable iff (!rst_sync_b)
        s_status_read
        |=> (rdata & 32'h3FFF_FFFD) == 32'h0000_0000)
        else $error("reserved status bits read nonzero");

    chk_status_read: assert property (@(posedge clock) disable iff (!rst_sync_b)
        s_status_read |=> rdata[`FSAC_BIT_FORCED] == $past(forced_q)
        && rdata[`FSAC_BIT_VECTOR_READ] == $past(vector_q))
        else $error("status flags read back wrong");

endmodule : fsac_fault_capture

// ---- rtl/fsac_defines.svh ----
/*
 * Register offsets, field positions, reset values and size codes for the
 * fault status and fault address capture block.
 * Assumes inclusion by bare name from the design module and the bench.
 */
`ifndef FSAC_DEFINES_SVH
`define FSAC_DEFINES_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define FSAC_OFF_HARD_FAULT_STATUS  8'h00
`define FSAC_OFF_MEM_FAULT_ADDR     8'h04
`define FSAC_OFF_BUS_FAULT_ADDR     8'h08
`define FSAC_OFF_ADDR_VALID         8'h0C
`define FSAC_OFF_ACCESS_ERROR       8'h10

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define FSAC_BIT_DEBUG_EVENT        31
`define FSAC_BIT_FORCED             30
`define FSAC_BIT_VECTOR_READ        1
`define FSAC_BIT_MEM_VALID          0
`define FSAC_BIT_BUS_VALID          1

// ----------------------------------------------------------------------
// Reset values and access size codes
// ----------------------------------------------------------------------
`define FSAC_RST_WORD               32'h0000_0000
`define FSAC_SIZE_WORD              2'h2

`endif

// ---- rtl/fsac_pkg.sv ----
/*
 * Types shared by the fault status and fault address capture block.
 * Assumes the defines header sits on the include path.
 */
package fsac_pkg;

    // ------------------------------------------------------------------
    // Register bus request
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic [1:0]  size;
        logic        wr;
        logic        rd;
    } fsac_req_t;

    // ------------------------------------------------------------------
    // Fault report from the core
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        forced;
        logic        vector_read;
        logic        mem_fault;
        logic [31:0] mem_addr;
        logic        bus_fault;
        logic        imprecise;
        logic [31:0] bus_addr;
    } fsac_fault_t;

    // Register bus decode state
    typedef enum logic [1:0] {
        FSAC_IDLE  = 2'b00,
        FSAC_READ  = 2'b01
    } fsac_bus_state_t;

endpackage : fsac_pkg

// ---- verif/fsac_core_model.sv ----
/*
 * Core-side fault source model: turns a one-cycle bench command into a
 * one-cycle fault report. Assumes commands change just after a rising edge.
 */
`timescale 1ns/1ps
module fsac_core_model
    import fsac_pkg::*;
(
    // Clock
    input  wire logic        clock,
    // Command from the bench
    input  wire logic        go,
    input  wire logic [2:0]  kind,
    input  wire logic [31:0] addr,
    // Fault report toward the block
    output fsac_fault_t      fault,
    output logic             debug_event
);
    // ------------------------------------------------------------------
    // Pulse generation
    // ------------------------------------------------------------------
    fsac_fault_t nxt;

    // Idle addresses carry the inverse, so a stale capture is never hidden
    always_comb begin
        nxt          = '0;
        nxt.mem_addr = ~addr;
        nxt.bus_addr = ~addr;
        if (go) begin
            case (kind)
                3'd0: nxt.forced = 1'b1;
                3'd1: nxt.vector_read = 1'b1;
                3'd2: begin
                    nxt.mem_fault = 1'b1;
                    nxt.mem_addr  = addr;
                end
                3'd3, 3'd4: begin
                    nxt.bus_fault = 1'b1;
                    nxt.imprecise = (kind == 3'd4);
                    nxt.bus_addr  = addr;
                end
                default: ;
            endcase
        end
    end

    // One register stage, so each report lasts exactly one cycle
    always_ff @(posedge clock) begin
        fault       <= nxt;
        debug_event <= go && (kind == 3'd5);
    end
endmodule : fsac_core_model

// ---- verif/fsac_fault_capture_tb.sv ----
/*
 * Self-checking bench for the fault capture block with a core model.
 * Assumes the package and defines header sit on the include path.
 */
`timescale 1ns/1ps
`include "fsac_defines.svh"
module fsac_fault_capture_tb
    import fsac_pkg::*;
;
    logic        clock, rst_b, go, vrf, spp, mv, bv, debug_event;
    logic [2:0]  kind;
    logic [31:0] rdata, faddr, seed, a, b;
    fsac_req_t   req;
    fsac_fault_t fault;
    int          num_errors, checked;

    fsac_fault_capture dut (.clock(clock), .rst_b(rst_b), .req(req), .rdata(rdata),
        .fault(fault), .debug_event(debug_event), .vector_read_fault_flag(vrf),
        .stack_preempted_pc(spp), .memory_protection_address_valid(mv),
        .bus_address_valid(bv));
    fsac_core_model core (.clock(clock), .go(go), .kind(kind), .addr(faddr),
        .fault(fault), .debug_event(debug_event));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Expected status word; reserved bits always zero
    function automatic logic [31:0] exp_status(int f, int v, int d);
        return {d[0], f[0], 28'h000_0000, v[0], 1'b0};
    endfunction : exp_status
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    task automatic check(logic [31:0] got, logic [31:0] exp, string msg);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : check
    task automatic wr(logic [7:0] ad, logic [31:0] d, logic [1:0] s = `FSAC_SIZE_WORD);
        @(posedge clock);
        req <= '{addr: ad, wdata: d, size: s, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        req.wr <= 1'b0;
    endtask : wr
    // Data is looked at only in the cycle after the strobe
    task automatic rd(logic [7:0] ad, logic [31:0] e, logic [1:0] s = `FSAC_SIZE_WORD);
        @(posedge clock);
        req <= '{addr: ad, wdata: 32'h0000_0000, size: s, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        req.rd <= 1'b0;
        #1 check(rdata, e, "read data");
    endtask : rd
    // Command, model pulse, capture edge, then settle
    task automatic fire(logic [2:0] k, logic [31:0] ad);
        @(posedge clock);
        go    <= 1'b1;
        kind  <= k;
        faddr <= ad;
        @(posedge clock);
        go <= 1'b0;
        @(posedge clock);
        #1;
    endtask : fire
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test

    // ------------------------------------------------------------------
    // Clock and watchdog
    // ------------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    initial begin
        repeat (5000) @(posedge clock);
        num_errors++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        finish_test();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        rst_b = 1'b0;
        req = '0;
        go = 1'b0;
        kind = 3'd0;
        faddr = 32'h0000_0000;
        seed = 32'd99011;
        num_errors = 0;
        checked = 0;
        repeat (8) @(posedge clock);
        rst_b <= 1'b1;
        repeat (3) @(posedge clock);
        rd(`FSAC_OFF_HARD_FAULT_STATUS, `FSAC_RST_WORD);
        rd(`FSAC_OFF_MEM_FAULT_ADDR, `FSAC_RST_WORD);
        rd(`FSAC_OFF_BUS_FAULT_ADDR, `FSAC_RST_WORD);
        rd(`FSAC_OFF_ADDR_VALID, `FSAC_RST_WORD);
        $display("test reset values done");
        fire(3'd0, 32'h0000_0000);
        rd(`FSAC_OFF_HARD_FAULT_STATUS, exp_status(1, 0, 0));
        rd(`FSAC_OFF_ADDR_VALID, `FSAC_RST_WORD);
        wr(`FSAC_OFF_HARD_FAULT_STATUS, 32'h0000_0000);
        rd(`FSAC_OFF_HARD_FAULT_STATUS, exp_status(1, 0, 0));
        fire(3'd1, 32'h0000_0000);
        check(32'({vrf, spp}), 32'h0000_0003, "vector flag");
        wr(`FSAC_OFF_HARD_FAULT_STATUS, 32'h4000_0000);
        rd(`FSAC_OFF_HARD_FAULT_STATUS, exp_status(0, 1, 0));
        wr(`FSAC_OFF_HARD_FAULT_STATUS, 32'h7FFF_FFFF);
        rd(`FSAC_OFF_HARD_FAULT_STATUS, `FSAC_RST_WORD);
        check(32'({vrf, spp}), 32'h0000_0000, "vector flag clear");
        $display("test sticky status done");
        for (int i = 0; i < 6; i++) begin
            a = xs();
            fire(3'd2, a);
            check(32'(mv), 32'h0000_0001, "mem valid");
            rd(`FSAC_OFF_MEM_FAULT_ADDR, a);
            rd(`FSAC_OFF_ADDR_VALID, 32'h0000_0001);
        end
        wr(`FSAC_OFF_ADDR_VALID, 32'h0000_0001);
        rd(`FSAC_OFF_ADDR_VALID, `FSAC_RST_WORD);
        a = xs() | 32'h0000_0001;
        fire(3'd3, a);
        check(32'(bv), 32'h0000_0001, "bus valid");
        rd(`FSAC_OFF_BUS_FAULT_ADDR, a);
        fire(3'd4, ~a);
        rd(`FSAC_OFF_BUS_FAULT_ADDR, a);
        b = xs();
        fire(3'd3, b);
        rd(`FSAC_OFF_BUS_FAULT_ADDR, b);
        rd(`FSAC_OFF_ADDR_VALID, 32'h0000_0002);
        $display("test fault addresses done");
        wr(`FSAC_OFF_BUS_FAULT_ADDR, xs(), 2'h0);
        wr(`FSAC_OFF_MEM_FAULT_ADDR, xs(), 2'h1);
        wr(8'h09, xs());
        rd(`FSAC_OFF_BUS_FAULT_ADDR, b);
        rd(8'h05, `FSAC_RST_WORD);
        rd(`FSAC_OFF_ACCESS_ERROR, 32'h0000_0001);
        wr(`FSAC_OFF_ACCESS_ERROR, 32'h0000_0001);
        rd(`FSAC_OFF_ACCESS_ERROR, `FSAC_RST_WORD);
        rd(8'h20, `FSAC_RST_WORD);
        a = xs();
        wr(`FSAC_OFF_BUS_FAULT_ADDR, a);
        rd(`FSAC_OFF_BUS_FAULT_ADDR, a);
        // Vector fault and its clearing write meet on one edge; the set must win
        fork
            fire(3'd1, 32'h0000_0000);
            begin
                @(posedge clock);
                wr(`FSAC_OFF_HARD_FAULT_STATUS, 32'h4000_0002);
            end
        join
        rd(`FSAC_OFF_HARD_FAULT_STATUS, exp_status(0, 1, 0));
        wr(`FSAC_OFF_HARD_FAULT_STATUS, 32'h0000_0002);
        rd(`FSAC_OFF_HARD_FAULT_STATUS, `FSAC_RST_WORD);
        fire(3'd5, 32'h0000_0000);
        rd(`FSAC_OFF_HARD_FAULT_STATUS, exp_status(0, 0, 1));
        $display("test access and debug done");
        // Mid-run reset must clear the valid, vector and status flags and the bus fault address
        @(posedge clock);
        rst_b <= 1'b0;
        repeat (2) @(posedge clock);
        #1 check(32'({mv, bv, vrf, spp}), 32'h0000_0000, "flags in reset");
        @(posedge clock);
        rst_b <= 1'b1;
        repeat (3) @(posedge clock);
        rd(`FSAC_OFF_HARD_FAULT_STATUS, `FSAC_RST_WORD);
        rd(`FSAC_OFF_BUS_FAULT_ADDR, `FSAC_RST_WORD);
        $display("test mid-run reset done");
        finish_test();
    end
endmodule : fsac_fault_capture_tb
